/* speif_host.sv */
// SPI host model driving frames in mode 0,0 or 1,1
`timescale 1ns/10ps
`default_nettype none

module speif_host (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so_o,
   input  wire logic so_oe
);
   logic mode11;
   wire  so_w;

   // Released so line shows the inverse of its last bit
   assign so_w = so_oe ? so_o : ~so_o;

   // Select low at power-up, so the first frame has no select fall
   initial begin
      mode11 = 1'b0;
      sck = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end

   // One frame, MSB first, optional pause before bit ha
   task automatic frame(input logic [63:0] tx, input int nb, input int ha,
                        output logic [63:0] rx, output logic oe);
      rx = 64'h0000_0000_0000_0000;
      oe = 1'b0;
      #3;
      sck = mode11;
      #15;
      cs_n = 1'b0;
      #15;
      for (int i = 0; i < nb; i++) begin
         sck = 1'b0;
         si = tx[nb-1-i];
         oe |= so_oe;
         #15;
         if (i == ha) begin
            hold_n = 1'b0;
            si = ~si;
            repeat (2) begin
               #15 sck = 1'b1;
               #15 sck = 1'b0;
            end
            #15 hold_n = 1'b1;
            si = tx[nb-1-i];
            #15;
         end
         sck = 1'b1;
         rx = {rx[62:0], so_w};
         oe |= so_oe;
         #15;
      end
      sck = mode11;
      #15;
      cs_n = 1'b1;
      si = ~si;
      #60;
   endtask
endmodule
`default_nettype wire

/* speif_pkg.sv */
// Shared constants and types of the SPI EEPROM protect interface
package speif_pkg;

   // ******************************************************
   // Geometry
   // ******************************************************
   localparam int ADDR_W       = 10;    // 1K bytes, low 10 address bits used
   localparam int ADDR_XFER_W  = 16;    // Address bits carried on the wire
   localparam int PAGE_W       = 5;     // 32 byte page

   // ******************************************************
   // Opcodes
   // ******************************************************
   localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_READ_STATUS       = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS      = 8'h01;
   localparam logic [7:0] OP_READ              = 8'h03;
   localparam logic [7:0] OP_WRITE             = 8'h02;

   // ******************************************************
   // Status register field positions and reset values
   // ******************************************************
   localparam int          POS_PROTECT_ENABLE   = 7;
   localparam int          POS_BLOCK_PROTECT_HI = 3;
   localparam int          POS_BLOCK_PROTECT_LO = 2;
   localparam int          POS_LATCH_FLAG       = 1;
   localparam int          POS_BUSY_FLAG        = 0;
   localparam logic        PROTECT_ENABLE_RST   = 1'b0;
   localparam logic [1:0]  BLOCK_PROTECT_RST    = 2'b00;
   localparam logic [7:0]  STATUS_WHILE_BUSY    = 8'hff;

   // Block protect encodings
   localparam logic [1:0]  BP_NONE    = 2'b00;
   localparam logic [1:0]  BP_QUARTER = 2'b01;
   localparam logic [1:0]  BP_HALF    = 2'b10;
   localparam logic [1:0]  BP_ALL     = 2'b11;

   // ******************************************************
   // Timing
   // ******************************************************
   localparam int WRITE_TIME_MS = 5;          // Self-timed write cycle, nominal
   localparam int REF_CLK_KHZ   = 100_000;    // ref_clk rate
   localparam int WRITE_CYCLES  = WRITE_TIME_MS * REF_CLK_KHZ;

   // ******************************************************
   // Types
   // ******************************************************
   typedef enum logic [3:0] {
      PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_READ_DATA, PH_WRITE_DATA,
      PH_STATUS_OUT, PH_STATUS_IN, PH_DONE, PH_IGNORE
   } speif_phase_t;

   typedef enum logic [1:0] {
      WS_IDLE, WS_COPY, WS_WAIT
   } speif_wstate_t;

   typedef struct packed {
      logic       protect_enable_bit;
      logic [2:0] dont_care;
      logic       block_protect_hi;
      logic       block_protect_lo;
      logic       latch_flag;
      logic       busy_flag;
   } speif_status_t;

endpackage

/* speif_top.sv */
// SPI EEPROM slave front end with write latch, status and block protection
//
// Operation
// R01: Sample input on rise, shift output on fall
// R02: Deselected: output high-Z, standby unless writing
// R03: Nothing starts before first select falling edge
// R04: Protect pin low plus enable blocks status writes
// R05: Protect pin fall while selected aborts status write
// R06: Protect pin ignored while enable bit is zero
// R07: Host moves pause only while clock low
// R08: Pause freezes sequence, resumes at same bit
// R09: Eight-bit opcode register, all transfers MSB first
// R10: First bit on first rise; clock may stop
// R11: Host holds select low, pause/protect high
// R12: Latch required to write; set/clear opcodes
// R13: Latch cleared at power-up and cycle end
// R14: Status read accepted anytime, even while busy
// R15: Status layout: enable, x, x, x, bp, latch, busy
// R16: Status write changes only enable and protect bits
// R17: Busy reads one during write, others one too
// R18: Block protect bits select protected upper ranges
// R19: Read opcode plus address streams array data
// R20: Write opcode plus address takes 1-32 bytes
// R21: Self-timed write cycle, busy until done
// R22: Works in clock modes 0,0 and 1,1
// R23: Sixteen address bits, low ten used
// R24: Read address increments, wraps top to zero
// R25: Page write address wraps within its page
// R26: Write starts only if select rises at byte end
// R27: Unknown opcode ignored until deselect
`timescale 1ns/10ps
`default_nettype none

module speif_top #(
   parameter int ADDR_W       = speif_pkg::ADDR_W,
   parameter int PAGE_W       = speif_pkg::PAGE_W,
   parameter int WRITE_CYCLES = speif_pkg::WRITE_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   input  wire logic hold_n,
   input  wire logic wp_n,
   output logic      so_o,
   output logic      so_oe,
   output logic      standby
);

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam int PAGE  = 1 << PAGE_W;

   // ******************************************************
   // Functions
   // ******************************************************

   // Opcode to phase; only status reads are taken while busy
   function automatic speif_pkg::speif_phase_t op_phase(input logic [7:0] op,
                                                       input logic       busy,
                                                       input logic       armed);
      speif_pkg::speif_phase_t ph;
      ph = speif_pkg::PH_IGNORE;                                   // see R27
      if (!armed)
         ph = speif_pkg::PH_IGNORE;                                // see R03
      else if (op == speif_pkg::OP_READ_STATUS)
         ph = speif_pkg::PH_STATUS_OUT;                            // see R14
      else if (busy)
         ph = speif_pkg::PH_IGNORE;
      else if (op == speif_pkg::OP_SET_WRITE_LATCH || op == speif_pkg::OP_CLEAR_WRITE_LATCH)
         ph = speif_pkg::PH_DONE;
      else if (op == speif_pkg::OP_WRITE_STATUS)
         ph = speif_pkg::PH_STATUS_IN;
      else if (op == speif_pkg::OP_READ || op == speif_pkg::OP_WRITE)
         ph = speif_pkg::PH_ADDR_HI;
      return ph;
   endfunction

   // True when an address falls inside the block-protected range
   function automatic logic is_protected(input logic [1:0]        bp,
                                         input logic [ADDR_W-1:0] a);
      logic [1:0] seg;
      seg = a[ADDR_W-1 -: 2];
      unique case (bp)
         speif_pkg::BP_NONE:    return 1'b0;
         speif_pkg::BP_QUARTER: return seg == 2'b11;               // see R18
         speif_pkg::BP_HALF:    return seg[1];
         speif_pkg::BP_ALL:     return 1'b1;
      endcase
   endfunction

   // ******************************************************
   // Shared state (ref_clk domain, read quasi-statically)
   // ******************************************************
   logic [7:0]           mem_q [0:(1 << ADDR_W) - 1];
   logic                 pe_q;
   logic [1:0]           bp_q;
   logic                 busy_q;
   logic                 done_tgl_q;
   logic                 armed_q;

   // ******************************************************
   // Link domain (sck)
   // ******************************************************
   // The frame logic is cleared by select high, so nothing survives a frame except the address, page buffer and commit snapshot,
   // the latch and the busy and done synchronisers, none of which select high clears.
   logic                       seq_rst;
   speif_pkg::speif_phase_t    phase_q, phase_d;
   logic [2:0]                 bit_q;
   logic [6:0]                 sh_q;
   logic [7:0]                 out_q;
   logic                       op_rd_q;
   logic                       so_q, drv_q;
   logic [ADDR_W-1:0]          addr_q;
   logic [7:0]                 pbuf_q [0:PAGE-1];
   logic [PAGE-1:0]            pmask_q;
   logic [7:0]                 swd_q;
   logic                       kind_stat_q;
   logic                       latch_q, latch_d;
   logic                       commit_q, commit_d;
   logic                       bz_s1, bz_s2;
   logic                       dn_s1, dn_s2, dn_s3;

   assign seq_rst = cs_n | rst;                                    // see R02

   // Decode of the byte being completed on this rising edge
   wire  logic [7:0]           byte_w   = {sh_q, si};              // see R09
   wire  logic                 byte_end = (bit_q == 3'h7);
   wire  logic                 op_end   = byte_end && phase_q == speif_pkg::PH_OPCODE;
   wire  logic                 done_evt = dn_s2 ^ dn_s3;
   wire  speif_pkg::speif_phase_t op_ph = op_phase(byte_w, bz_s2, armed_q);
   wire  logic                 op_ok    = op_end && op_ph == speif_pkg::PH_DONE;
   wire  logic                 wr_end   = byte_end && phase_q == speif_pkg::PH_WRITE_DATA;
   wire  logic                 rd_end   = byte_end && phase_q == speif_pkg::PH_READ_DATA;
   wire  logic                 al_end   = byte_end && phase_q == speif_pkg::PH_ADDR_LO;
   wire  logic [ADDR_W-1:0]    rd_idx   = rd_end ? addr_q : {addr_q[ADDR_W-1 -: 2], byte_w};
   wire  logic [ADDR_W-1:0]    rd_next  = rd_idx + 1'b1;           // see R24
   // Settled phase only: the next-phase decode still sees si moving on this fall
   wire  logic                 shifting = phase_q == speif_pkg::PH_READ_DATA
                                       || phase_q == speif_pkg::PH_STATUS_OUT;

   // Status byte as seen on the wire
   speif_pkg::speif_status_t   stat_w;
   always_comb begin
      stat_w                    = '0;
      stat_w.protect_enable_bit = pe_q;                            // see R15
      stat_w.block_protect_hi   = bp_q[1];
      stat_w.block_protect_lo   = bp_q[0];
      stat_w.latch_flag         = latch_q;
      if (bz_s2)
         stat_w = speif_pkg::STATUS_WHILE_BUSY;                    // see R17
   end

   // Phase sequencing of one frame
   always_comb begin
      phase_d = phase_q;
      if (byte_end) begin
         unique case (phase_q)
            speif_pkg::PH_OPCODE:     phase_d = op_ph;
            speif_pkg::PH_ADDR_HI:    phase_d = speif_pkg::PH_ADDR_LO;     // see R23
            speif_pkg::PH_ADDR_LO:    phase_d = op_rd_q ? speif_pkg::PH_READ_DATA
                                                        : speif_pkg::PH_WRITE_DATA;
            speif_pkg::PH_STATUS_IN:  phase_d = speif_pkg::PH_DONE;
            speif_pkg::PH_READ_DATA,
            speif_pkg::PH_WRITE_DATA,
            speif_pkg::PH_STATUS_OUT,
            speif_pkg::PH_DONE,
            speif_pkg::PH_IGNORE:     phase_d = phase_q;
         endcase
      end
   end

   // Latch: hardware clear at cycle end, a command on the same edge wins
   always_comb begin
      latch_d = latch_q;
      if (done_evt)
         latch_d = 1'b0;                                           // see R13
      if (op_ok)
         latch_d = (byte_w == speif_pkg::OP_SET_WRITE_LATCH);      // see R12
   end

   // Commit holds only directly after a whole data byte
   assign commit_d = (wr_end || (byte_end && phase_q == speif_pkg::PH_STATUS_IN))
                     && latch_q;                                   // see R26

   // Frame shifter, bit counter and phase; paused edges change nothing
   always_ff @(posedge sck or posedge seq_rst) begin
      if (seq_rst) begin
         phase_q <= speif_pkg::PH_OPCODE;
         bit_q   <= 3'h0;                                          // see R10
         sh_q    <= 7'h00;
         out_q   <= 8'h00;
         op_rd_q <= 1'b0;
      end else if (hold_n) begin                                   // see R08
         phase_q <= phase_d;
         bit_q   <= bit_q + 3'h1;                                  // see R01
         sh_q    <= byte_w[6:0];
         if (op_end)
            op_rd_q <= (byte_w == speif_pkg::OP_READ);             // see R19
         if ((op_end && op_ph == speif_pkg::PH_STATUS_OUT)
             || (byte_end && phase_q == speif_pkg::PH_STATUS_OUT))
            out_q <= stat_w;
         else if ((al_end && op_rd_q) || rd_end)
            out_q <= mem_q[rd_idx];
      end
   end

   // Address, page buffer and commit snapshot, kept across deselect
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         addr_q      <= '0;
         pmask_q     <= '0;
         swd_q       <= 8'h00;
         kind_stat_q <= 1'b0;
         latch_q     <= 1'b0;                                      // see R13
         commit_q    <= 1'b0;
      end else if (hold_n && !cs_n) begin
         latch_q  <= latch_d;
         commit_q <= commit_d;
         if (op_end && op_ph == speif_pkg::PH_ADDR_HI) begin
            kind_stat_q <= 1'b0;
            pmask_q     <= '0;
         end
         if (op_end && op_ph == speif_pkg::PH_STATUS_IN)
            kind_stat_q <= 1'b1;
         if (byte_end && phase_q == speif_pkg::PH_STATUS_IN)
            swd_q <= byte_w;
         if (byte_end && phase_q == speif_pkg::PH_ADDR_HI)
            addr_q[ADDR_W-1 -: 2] <= byte_w[1:0];
         if (al_end)
            addr_q <= op_rd_q ? rd_next : rd_idx;
         if (rd_end)
            addr_q <= rd_next;
         if (wr_end) begin
            pmask_q[addr_q[PAGE_W-1:0]] <= 1'b1;                   // see R20
            addr_q[PAGE_W-1:0]          <= addr_q[PAGE_W-1:0] + 1'b1; // see R25
         end
      end
   end

   // Page buffer storage
   always_ff @(posedge sck) begin
      if (wr_end && hold_n && !cs_n)
         pbuf_q[addr_q[PAGE_W-1:0]] <= byte_w;
   end

   // Busy level and cycle-done toggle into the link domain
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         bz_s1 <= 1'b0;
         bz_s2 <= 1'b0;
         dn_s1 <= 1'b0;
         dn_s2 <= 1'b0;
         dn_s3 <= 1'b0;
      end else begin
         bz_s1 <= busy_q;
         bz_s2 <= bz_s1;
         // Advance only on edges the latch takes, so no cycle-done event is lost
         if (hold_n && !cs_n) begin                                // see R13
            dn_s1 <= done_tgl_q;
            dn_s2 <= dn_s1;
            dn_s3 <= dn_s2;
         end
      end
   end

   // Serial output changes on the falling edge, and clears to zero when select rises
   always_ff @(negedge sck or posedge seq_rst) begin
      if (seq_rst) begin
         so_q  <= 1'b0;
         drv_q <= 1'b0;
      end else if (hold_n) begin
         so_q  <= out_q[~bit_q];                                   // see R01
         drv_q <= shifting;                                        // see R22
      end
   end

   // Output driven only while selected and not paused
   assign so_o  = so_q;
   assign so_oe = drv_q && !cs_n && hold_n;                        // see R02

   // ******************************************************
   // System domain (ref_clk)
   // ******************************************************
   logic                     cs_s1, cs_s2, cs_s3;
   logic                     wp_s1, wp_s2, wp_s3;
   logic                     cm_s1, cm_s2;
   logic                     abort_q, consumed_q, standby_q;
   speif_pkg::speif_wstate_t ws_q;
   logic [PAGE_W-1:0]        idx_q;
   logic [CNT_W-1:0]         cnt_q;

   wire logic              cs_rise  = cs_s2 && !cs_s3;
   wire logic              cs_fall  = !cs_s2 && cs_s3;
   wire logic              wp_fall  = !wp_s2 && wp_s3;
   wire logic              launch   = cs_rise && cm_s2 && !consumed_q && ws_q == speif_pkg::WS_IDLE;
   wire logic              stat_ok  = !(pe_q && !wp_s2) && !abort_q;        // see R04
   wire logic [ADDR_W-1:0] cp_addr  = {addr_q[ADDR_W-1:PAGE_W], idx_q};
   wire logic              cp_wr    = ws_q == speif_pkg::WS_COPY && pmask_q[idx_q]
                                      && !is_protected(bp_q, cp_addr);      // see R18

   // Pin synchronisers; commit snapshot is stable once the clock stopped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Select history starts low, so a select held low across reset never arms
         cs_s1 <= 1'b0;                                            // see R03
         cs_s2 <= 1'b0;
         cs_s3 <= 1'b0;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
         wp_s3 <= 1'b1;
         cm_s1 <= 1'b0;
         cm_s2 <= 1'b0;
      end else begin
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         wp_s1 <= wp_n;
         wp_s2 <= wp_s1;
         wp_s3 <= wp_s2;
         cm_s1 <= commit_q;
         cm_s2 <= cm_s1;
      end
   end

   // Arming, abort and commit bookkeeping
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed_q    <= 1'b0;
         abort_q    <= 1'b0;
         consumed_q <= 1'b0;
         standby_q  <= 1'b1;
      end else begin
         if (cs_s2)
            armed_q <= 1'b1;                                       // see R03
         if (cs_fall)
            abort_q <= 1'b0;
         if (wp_fall && !cs_s2 && pe_q)
            abort_q <= 1'b1;                                       // see R05
         if (!cm_s2)
            consumed_q <= 1'b0;
         if (launch)
            consumed_q <= 1'b1;
         standby_q <= cs_s2 && !busy_q;                            // see R02
      end
   end

   // Self-timed write cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ws_q       <= speif_pkg::WS_IDLE;
         busy_q     <= 1'b0;
         done_tgl_q <= 1'b0;
         idx_q      <= '0;
         cnt_q      <= '0;
         pe_q       <= speif_pkg::PROTECT_ENABLE_RST;
         bp_q       <= speif_pkg::BLOCK_PROTECT_RST;
      end else begin
         unique case (ws_q)
            speif_pkg::WS_IDLE: begin
               idx_q <= '0;
               cnt_q <= CNT_W'(WRITE_CYCLES - 1);
               if (launch && !kind_stat_q) begin
                  ws_q   <= speif_pkg::WS_COPY;
                  busy_q <= 1'b1;                                  // see R21
               end else if (launch && stat_ok) begin               // see R06
                  pe_q   <= swd_q[speif_pkg::POS_PROTECT_ENABLE];  // see R16
                  bp_q   <= {swd_q[speif_pkg::POS_BLOCK_PROTECT_HI],
                             swd_q[speif_pkg::POS_BLOCK_PROTECT_LO]};
                  ws_q   <= speif_pkg::WS_WAIT;
                  busy_q <= 1'b1;
               end
            end
            speif_pkg::WS_COPY: begin
               idx_q <= idx_q + 1'b1;
               if (&idx_q)
                  ws_q <= speif_pkg::WS_WAIT;
            end
            speif_pkg::WS_WAIT: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_q == '0) begin
                  ws_q       <= speif_pkg::WS_IDLE;
                  busy_q     <= 1'b0;
                  done_tgl_q <= !done_tgl_q;                       // see R13
               end
            end
         endcase
      end
   end

   // Array cells, written from the page buffer during the cycle
   always_ff @(posedge ref_clk) begin
      if (cp_wr)
         mem_q[cp_addr] <= pbuf_q[idx_q];
   end

   assign standby = standby_q;

endmodule

`default_nettype wire

/* speif_top_asserts.sv */
// Port checker for the SPI EEPROM protect interface
`timescale 1ns/10ps
`default_nettype none

module speif_top_asserts (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_o,
   input wire logic so_oe,
   input wire logic standby
);
   logic [4:0] rise_q;

   // Counts unpaused sck rises since the frame opened
   always_ff @(posedge sck or posedge cs_n or posedge rst) begin
      if (rst || cs_n) begin
         rise_q <= 5'h00;
      end else if (hold_n && rise_q != 5'h1f) begin
         rise_q <= rise_q + 5'h01;
      end
   end

   AST_OE_DESEL: assert property (@(posedge ref_clk) disable iff (rst)
      cs_n |-> !so_oe) else $error("so driven while deselected");
   AST_OE_PAUSE: assert property (@(posedge ref_clk) disable iff (rst)
      !hold_n |-> !so_oe) else $error("so driven while paused");
   AST_STBY: assert property (@(posedge ref_clk) disable iff (rst)
      (!cs_n) [*5] |-> !standby) else $error("standby while selected");
   AST_RST_OE: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> !so_oe) else $error("so driven after reset");
   AST_SO_FALL: assert property (@(posedge ref_clk) disable iff (rst)
      $changed(so_o) && !cs_n && $past(!cs_n) |-> !sck) else $error("so moved off fall");
   AST_OE_LATE: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(so_oe) |-> !sck) else $error("so enable rose with sck high");
   AST_OE_COUNT: assert property (@(posedge sck) disable iff (rst || cs_n)
      rise_q < 5'h08 |-> !so_oe) else $error("so driven inside opcode");
   AST_SO_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      !hold_n && $past(!hold_n) && !cs_n |-> $stable(so_o)) else $error("so moved in pause");

   // Main scenarios reached
   COV_OE: cover property (@(posedge ref_clk) $rose(so_oe));
   COV_PAUSE: cover property (@(posedge ref_clk) !hold_n && !cs_n);
   COV_STBY: cover property (@(posedge ref_clk) $fell(standby));
endmodule

bind speif_top speif_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n),
   .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .standby(standby));
`default_nettype wire

/* tb_spi_eeprom_protect_interface.sv */
// Self-checking bench of the SPI EEPROM protect interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end

module tb_spi_eeprom_protect_interface;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        wp_n = 1'b1;
   wire logic   sck, cs_n, si, hold_n, so_o, so_oe, standby;
   logic [63:0] rx;
   logic        oe;
   logic [7:0]  v;
   int          checked = 0;
   int          mismatches = 0;

   // 100 MHz system clock
   always #5 ref_clk = ~ref_clk;

   speif_top #(.WRITE_CYCLES(50)) dut (.ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n),
      .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .standby(standby));
   speif_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o),
      .so_oe(so_oe));

   task automatic stop_test();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ******************************************************
   // Frame helpers
   // ******************************************************
   task automatic frm(input logic [63:0] tx, input int nb, input int ha);
      @(negedge ref_clk);
      u_host.frame(tx, nb, ha, rx, oe);
   endtask
   task automatic read_status_cmd();
      frm({8'h05, 8'h00}, 16, -1);
      v = rx[7:0];
   endtask
   task automatic write_status_cmd(input logic [7:0] d);
      frm({8'h06}, 8, -1);
      frm({8'h01, d}, 16, -1);
   endtask
   // Polls until the write cycle ends, then reads status again
   task automatic wait_idle();
      read_status_cmd();
      `CHK(v, 8'hff)
      for (int n = 0; n < 20 && v === 8'hff; n++) read_status_cmd();
      if (v === 8'hff) begin
         mismatches++;
         stop_test();
      end
      read_status_cmd();
   endtask

   // ******************************************************
   // Scenarios
   // ******************************************************
   task automatic t_power();
      read_status_cmd();
      `CHK(oe, 1'b0)
      read_status_cmd();
      `CHK(v, 8'h00)
      `CHK(standby, 1'b1)
   endtask
   task automatic t_latch();
      frm({8'h06}, 8, -1);
      read_status_cmd();
      `CHK(v, 8'h02)
      frm({8'h04}, 8, -1);
      frm({8'h02, 16'h03ff, 8'h11}, 32, -1);
      read_status_cmd();
      `CHK(v, 8'h00)
   endtask
   task automatic t_page();
      frm({8'h06}, 8, -1);
      frm({8'h02, 16'h03fe, 8'ha1, 8'ha2, 8'ha3}, 48, -1);
      wait_idle();
      `CHK(v, 8'h00)
      frm({8'h06}, 8, -1);
      frm({8'h02, 16'h0000, 8'h5c}, 32, -1);
      wait_idle();
      frm({8'h03, 16'hffff, 16'h0000}, 40, -1);
      `CHK(rx[15:0], 16'ha25c)
      u_host.mode11 = 1'b1;
      frm({8'h03, 16'h03e0, 8'h00}, 32, 12);
      `CHK(rx[7:0], 8'ha3)
      u_host.mode11 = 1'b0;
   endtask
   task automatic t_protect();
      wp_n = 1'b0;
      write_status_cmd(8'h04);
      wait_idle();
      `CHK(v, 8'h04)
      frm({8'h06}, 8, -1);
      frm({8'h02, 16'h03ff, 8'h77}, 32, -1);
      wait_idle();
      frm({8'h03, 16'h03ff, 8'h00}, 32, -1);
      `CHK(rx[7:0], 8'ha2)
   endtask
   task automatic t_status();
      wp_n = 1'b1;
      write_status_cmd(8'hff);
      wait_idle();
      `CHK(v, 8'h8c)
      wp_n = 1'b0;
      write_status_cmd(8'h00);
      read_status_cmd();
      `CHK(v, 8'h8e)
      wp_n = 1'b1;
      fork
         frm({8'h01, 8'h00}, 16, -1);
         begin
            repeat (20) @(negedge ref_clk);
            wp_n = 1'b0;
            repeat (5) @(negedge ref_clk);
            wp_n = 1'b1;
         end
      join
      read_status_cmd();
      `CHK(v, 8'h8e)
      frm({8'h01, 8'h00}, 16, -1);
      wait_idle();
      `CHK(v, 8'h00)
   endtask
   task automatic t_cancel();
      frm({8'h06}, 8, -1);
      frm({8'h02, 16'h0100, 4'h5}, 28, -1);
      read_status_cmd();
      `CHK(v, 8'h02)
      frm({8'hab, 8'h00}, 16, -1);
      `CHK(oe, 1'b0)
   endtask

   // Reset for 10 cycles, then run every scenario
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      t_power();
      t_latch();
      t_page();
      t_protect();
      t_status();
      t_cancel();
      stop_test();
   end
endmodule
`default_nettype wire
